// ===== hdl/evr_router.sv
// Peripheral event router: four channel multiplexers with pin filtering
// and quadrature decoding. Assumes all producers and consumers run on clk
// and that configuration ports are held stable by the system.
`timescale 1ns/100ps

// Behaviour
// RULE_01: Four independent channels each pick their source from their own setting.
// RULE_02: A raised event appears on the channel output at most two clocks later; pin events with their filter on take filt_len + 2 clocks.
// RULE_03: Routing has no sleep gating, so it runs in active and idle sleep alike.
// RULE_04: Software strobes and a peripheral clock tick are selectable sources.
// RULE_05: Converter, comparator, pin, counter, timer, infrared and USB events connect.
// RULE_06: Delivery is pure hardware with no processor or interrupt step.
// RULE_07: Producers pulse their event line on the state change they report.
// RULE_08: Pin events can be filtered and channel pairs decoded as quadrature; only channels 0 and 1 decode, under cfg[0].quad_en.
// RULE_09: All consumers of a channel see its event on the same cycle.
// RULE_10: The off setting keeps the channel output inactive.
module evr_router #(
  parameter int NUM_CH = evr_pkg::NUM_CH
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // Configuration, one entry per channel, and the idle sleep flag
  input  wire evr_pkg::evr_cfg_t [3:0]    cfg,
  input  wire logic [3:0]                 sw_strobe,
  input  wire logic                       sleep_idle,
  // Event producers
  input  wire evr_pkg::evr_src_t          src,
  input  wire logic                       perclk_tick,
  // Event consumers
  output logic [3:0]                      ch_event,
  output logic [15:0]                     quad_count,
  output logic                            quad_dir,
  output logic                            quad_err
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]            ch;
    logic [3:0]            sw;
    logic                  pclk;
    logic [1:0]            qab;
    logic [15:0]           qcnt;
    logic                  qdir;
    logic                  qerr;
    evr_pkg::evr_qd_state_t qst;
  } evr_state_t;

  evr_state_t st_reg;
  evr_state_t st_next;

  logic [3:0]  pin_filt;
  logic [15:0] src_vec;
  logic [3:0]  ch_raw;

  // ---------------------------------------------------------------
  // Pin filters
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_filt
      evr_filter u_filt (
        .clk  (clk),
        .nrst (nrst),
        .en   (cfg[gi].filt_en),
        .len  (cfg[gi].filt_len),
        .din  (src.pin_ev[gi]),
        .dout (pin_filt[gi])
      ); // RULE_08
    end
  endgenerate

  // Select one source; unknown or off codes give no event
  function automatic logic pick(input logic [4:0] sel,
                                input logic [15:0] v,
                                input logic sw,
                                input logic pc);
    logic r;
    r = 1'b0;
    if (sel == evr_pkg::SEL_SW) begin
      r = sw; // RULE_04
    end else if (sel == evr_pkg::SEL_PERCLK) begin
      r = pc; // RULE_04
    end else if (sel[4]) begin
      r = v[sel[3:0]];
    end
    return r; // RULE_10
  endfunction

  // ---------------------------------------------------------------
  // Routing
  // ---------------------------------------------------------------
  // Pin events pass the filter stage first, so they arrive one cycle (filt_len + 1 with the
  // filter on) after other peripheral sources; with the filter off, both stay within two cycles.
  always_comb begin
    src_vec = {src.adc_ev, src.acmp_ev, pin_filt, src.rtc_ev,
               src.tc_ev, src.infrared_comm_module_ev,
               src.usb_ev}; // RULE_05
    for (int c = 0; c < 4; c++) begin
      ch_raw[c] = pick(cfg[c].sel, src_vec, st_reg.sw[c],
                       st_reg.pclk); // RULE_01
    end
  end

  // Gray step table for quadrature: +1, -1, or illegal double step
  function automatic logic [1:0] qstep(input logic [1:0] o,
                                       input logic [1:0] n);
    logic [1:0] r;
    r = 2'h0;
    if (o != n) begin
      if ((o ^ n) == 2'h3) begin
        r = 2'h3;
      end else if ({o[0] ^ n[1]} == 1'b1) begin
        r = 2'h1;
      end else begin
        r = 2'h2;
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [1:0] step;
    step = qstep(st_reg.qab, {st_reg.ch[0], st_reg.ch[1]});
    st_next = st_reg;
    // No dependency on sleep_idle: events route in idle sleep too
    st_next.sw   = sw_strobe; // RULE_03
    st_next.pclk = perclk_tick;
    st_next.ch   = ch_raw; // RULE_02 RULE_06 RULE_09
    st_next.qab  = {st_reg.ch[0], st_reg.ch[1]};
    case (st_reg.qst)
      evr_pkg::QD_IDLE: begin
        if (cfg[0].quad_en && step != 2'h0) begin
          st_next.qst = evr_pkg::QD_STEP;
        end
      end
      evr_pkg::QD_STEP: begin
        if (!cfg[0].quad_en) begin
          st_next.qst = evr_pkg::QD_IDLE;
        end else if (step == 2'h3) begin
          st_next.qerr = 1'b1;
          st_next.qst  = evr_pkg::QD_ERR;
        end else if (step == 2'h1) begin
          st_next.qcnt = st_reg.qcnt + 16'h0001; // RULE_08
          st_next.qdir = 1'b0;
        end else if (step == 2'h2) begin
          st_next.qcnt = st_reg.qcnt - 16'h0001; // RULE_08
          st_next.qdir = 1'b1;
        end
      end
      evr_pkg::QD_ERR: begin
        // Error holds until decoding is turned off
        if (!cfg[0].quad_en) begin
          st_next.qerr = 1'b0;
          st_next.qst  = evr_pkg::QD_IDLE;
        end
      end
      default: begin
        st_next.qst = evr_pkg::QD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg      <= '0;
      st_reg.qcnt <= evr_pkg::QCNT_RST;
      st_reg.qst  <= evr_pkg::QD_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ch_event   = st_reg.ch;
  assign quad_count = st_reg.qcnt;
  assign quad_dir   = st_reg.qdir;
  assign quad_err   = st_reg.qerr;

endmodule // evr_router

// ===== inc/evr_pkg.sv
// Package for the peripheral event router: widths, selector codes, types.
// Assumes a single peripheral clock domain and no software bus.
package evr_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_CH     = 4;
  localparam int NUM_SRC    = 16;
  localparam int SEL_W      = 5;
  localparam int FILT_W     = 3;
  localparam int FILT_DEF   = 3;
  localparam int QCNT_W     = 16;

  // ---------------------------------------------------------------
  // Source selector codes
  // ---------------------------------------------------------------
  localparam logic [4:0] SEL_OFF     = 5'h00;
  localparam logic [4:0] SEL_SW      = 5'h01;
  localparam logic [4:0] SEL_PERCLK  = 5'h02;
  localparam logic [4:0] SEL_PERIPH0 = 5'h10;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [4:0] SEL_RST     = 5'h00;
  localparam logic [2:0] FILT_RST    = 3'h0;
  localparam logic [15:0] QCNT_RST   = 16'h0000;

  // Peripheral source vector: one bit per producer
  typedef struct packed {
    logic [3:0] adc_ev;
    logic [1:0] acmp_ev;
    logic [3:0] pin_ev;
    logic       rtc_ev;
    logic [2:0] tc_ev;
    logic       infrared_comm_module_ev;
    logic       usb_ev;
  } evr_src_t;

  // Per channel configuration
  typedef struct packed {
    logic [4:0] sel;
    logic       filt_en;
    logic [2:0] filt_len;
    logic       quad_en;
  } evr_cfg_t;

  typedef enum logic [2:0] {
    QD_IDLE = 3'b001,
    QD_STEP = 3'b010,
    QD_ERR  = 3'b100
  } evr_qd_state_t;

endpackage

// ===== hdl/evr_filter.sv
// Digital input filter: output follows input once it has held steady.
// Assumes input synchronous to clk; length 0 passes data one cycle late.
`timescale 1ns/100ps

module evr_filter (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Control
  input  wire logic       en,
  input  wire logic [2:0] len,
  // Data
  input  wire logic       din,
  output logic            dout
);

  typedef struct packed {
    logic       out;
    logic [2:0] cnt;
  } evr_filt_state_t;

  evr_filt_state_t st_reg;
  evr_filt_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (!en || din == st_reg.out) begin
      st_next.cnt = 3'h0;
      st_next.out = din;
    end else if (st_reg.cnt >= len) begin
      st_next.cnt = 3'h0;
      st_next.out = din;
    end else begin
      st_next.cnt = st_reg.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.out;

endmodule // evr_filter

// ===== verification/evr_producers.sv
// Producer model: random event pulses on every peripheral source.
// Assumes the bench may take the lines over with a fixed pattern.
`timescale 1ns/100ps
module evr_producers (
  // Clock
  input  wire logic        clk,
  // Override
  input  wire logic        manual,
  input  wire logic [15:0] man_v,
  // Events
  output evr_pkg::evr_src_t src,
  output logic             perclk_tick
);
  initial src = '0;
  initial perclk_tick = 1'b0;
  // Right-hand side taken at the edge, so the override never races
  always @(posedge clk) begin
    src <= #1 manual ? man_v : 16'($urandom);
    perclk_tick <= #1 1'($urandom);
  end
endmodule // evr_producers

// ===== verification/evr_router_asserts.sv
// Checker for the event router: routing delays and quiet settings.
// Assumes binding to evr_router; judges routing only once cfg has settled.
`timescale 1ns/100ps
module evr_router_asserts (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    nrst,
  // Watched signals
  input wire evr_pkg::evr_cfg_t [3:0] cfg,
  input wire logic [3:0]              sw_strobe,
  input wire evr_pkg::evr_src_t       src,
  input wire logic                    perclk_tick,
  input wire logic [3:0]              ch_event,
  input wire logic [15:0]             quad_count,
  input wire logic                    quad_err
);
  logic [15:0]             src_q, src_q2;
  logic [3:0]              sw_q1, sw_q2;
  logic [1:0]              pc_q, stab;
  evr_pkg::evr_cfg_t [3:0] cfg_q;
  wire logic               calm = stab == 2'h3 && cfg == cfg_q;
  // Events in flight across a cfg change are not judged
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {src_q, src_q2, sw_q1, sw_q2, pc_q, stab, cfg_q} <= '0;
    end else begin
      src_q <= src;
      src_q2 <= src_q;
      sw_q1 <= sw_strobe;
      sw_q2 <= sw_q1;
      pc_q  <= {pc_q[0], perclk_tick};
      stab  <= (cfg != cfg_q) ? 2'h0 : (stab == 2'h3) ? stab : stab + 2'h1;
      cfg_q <= cfg;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  for (genvar i = 0; i < 4; i++) begin : g_ch
    wire logic [4:0] s   = cfg[i].sel;
    // Pin bits 6..9 pass the filter of the same pin index
    wire logic       pin = s[3:0] >= 4'h6 && s[3:0] <= 4'h9;
    wire logic [1:0] fi  = s[1:0] - 2'h2;
    wire logic       ok  = calm && !(pin && cfg[fi].filt_en);
    a_periph_one_cycle: assert property (
      ok && s[4] && !pin |-> ch_event[i] == src_q[s[3:0]])
      else $error("bad route");
    a_pin_two_cycle: assert property (
      ok && s[4] && pin |-> ch_event[i] == src_q2[s[3:0]])
      else $error("bad pin route");
    a_soft_two_cycle: assert property (
      ok && s == evr_pkg::SEL_SW |-> ch_event[i] == sw_q2[i])
      else $error("bad soft event");
    a_tick_two_cycle: assert property (
      ok && s == evr_pkg::SEL_PERCLK |-> ch_event[i] == pc_q[1])
      else $error("bad tick event");
    a_off_quiet: assert property (
      calm && s == evr_pkg::SEL_OFF |-> !ch_event[i]) else $error("off busy");
    a_reserved_quiet: assert property (
      calm && !s[4] && s > 5'h02 |-> !ch_event[i]) else $error("bad code");
  end
  a_same_cycle_fanout: assert property (
    calm && cfg[1] == cfg[0] && cfg[0].sel != evr_pkg::SEL_SW
    |-> ch_event[1] == ch_event[0]) else $error("channels out of step");
  a_quad_err_sticky: assert property (
    quad_err && cfg[0].quad_en ##1 cfg[0].quad_en |-> quad_err)
    else $error("decoder error dropped");
  a_quad_count_hold: assert property (
    !cfg[0].quad_en [*3] |-> $stable(quad_count)) else $error("count moved");
endmodule // evr_router_asserts

// ===== verification/evr_router_bench.sv
// Bench for the event router: random routing runs, filter and decoder.
// Assumes the producer model drives the peripheral sources.
`timescale 1ns/100ps
module evr_router_bench;
  logic                    clk = 1'b0, nrst = 1'b0;
  evr_pkg::evr_cfg_t [3:0] cfg = '0;
  logic [3:0]              sw_strobe = 4'h0, ch_event, h_sw1, h_sw2;
  logic                    sleep_idle = 1'b0, manual = 1'b0;
  logic [15:0]             man_v = 16'h0000, quad_count, h_src, h_src2;
  evr_pkg::evr_src_t       src;
  logic                    perclk_tick, quad_dir, quad_err;
  logic [1:0]              h_pc;
  logic [1:0]              qs [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  logic [1:0]              rs [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
  int                      fail_count = 0, total_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  evr_producers i_prod (.clk(clk), .manual(manual), .man_v(man_v),
    .src(src), .perclk_tick(perclk_tick));
  evr_router i_dut (.clk(clk), .nrst(nrst), .cfg(cfg),
    .sw_strobe(sw_strobe), .sleep_idle(sleep_idle), .src(src),
    .perclk_tick(perclk_tick), .ch_event(ch_event),
    .quad_count(quad_count), .quad_dir(quad_dir), .quad_err(quad_err));
  // ----
  // Helpers
  // ----
  task automatic check(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic exp_ch(input logic [4:0] s, input int i);
    if (s == evr_pkg::SEL_SW) return h_sw2[i];
    if (s == evr_pkg::SEL_PERCLK) return h_pc[1];
    // Pin events pass the filter stage, one cycle behind the rest
    if (s[4] && s[3:0] >= 4'h6 && s[3:0] <= 4'h9) return h_src2[s[3:0]];
    return s[4] ? h_src[s[3:0]] : 1'b0;
  endfunction
  // Check just after the edge, drive one step later
  task automatic tick(input bit chk);
    @(posedge clk);
    #0.5;
    for (int i = 0; i < 4; i++) begin
      if (chk) check(ch_event[i] === exp_ch(cfg[i].sel, i), "route");
    end
    #0.5;
    sw_strobe = 4'($urandom);
    sleep_idle = 1'($urandom);
  endtask
  always @(posedge clk) begin
    h_src <= src;
    h_src2 <= h_src;
    h_sw1 <= sw_strobe;
    h_sw2 <= h_sw1;
    h_pc  <= {h_pc[0], perclk_tick};
    cyc   <= cyc + 1;
    if (cyc > 2000) begin
      check(1'b0, "timeout");
      end_of_test();
    end
  end
  initial begin
    void'($urandom(2));
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    check(ch_event === 4'h0 && quad_count === 16'h0000, "reset");
    for (int k = 0; k < 32; k++) begin
      for (int i = 0; i < 4; i++) cfg[i].sel = 5'(k + 8 * i);
      if (k[0]) cfg[1] = cfg[0];
      repeat (5) tick(0);
      repeat (12) tick(1);
    end
    cfg = '0;
    cfg[2] = '{sel: 5'h18, filt_en: 1'b1, filt_len: 3'h3, quad_en: 1'b0};
    manual = 1'b1;
    repeat (6) tick(0);
    man_v = 16'h0100;
    tick(0);
    man_v = 16'h0000;
    repeat (10) begin
      tick(0);
      check(ch_event[2] === 1'b0, "glitch passed");
    end
    man_v = 16'h0100;
    repeat (5) tick(0);
    check(ch_event[2] === 1'b0, "filter early");
    tick(0);
    check(ch_event[2] === 1'b1, "filter stuck");
    cfg = '0;
    cfg[0].sel = 5'h10;
    cfg[1].sel = 5'h11;
    man_v = 16'h0000;
    repeat (4) tick(0);
    cfg[0].quad_en = 1'b1;
    foreach (qs[j]) begin
      man_v = 16'(qs[j]);
      repeat (4) tick(0);
    end
    check(quad_count === 16'h0003 && quad_dir === 1'b0, "count");
    man_v = 16'h0003;
    repeat (4) tick(0);
    check(quad_err === 1'b1, "no error");
    cfg[0].quad_en = 1'b0;
    repeat (4) tick(0);
    check(quad_err === 1'b0, "error kept");
    cfg[0].quad_en = 1'b1;
    foreach (rs[j]) begin
      man_v = 16'(rs[j]);
      repeat (4) tick(0);
    end
    check(quad_count === 16'h0000 && quad_dir === 1'b1, "down");
    end_of_test();
  end
endmodule // evr_router_bench
bind evr_router evr_router_asserts i_chk (.clk(clk), .nrst(nrst),
  .cfg(cfg), .sw_strobe(sw_strobe), .src(src), .perclk_tick(perclk_tick),
  .ch_event(ch_event), .quad_count(quad_count), .quad_err(quad_err));
